// ===== pcs_mem_model.sv
// Purpose: Program ROM and address stack facing the sequencer
// Assumes: Push and pop are one-cycle strobes
// Notes:   Rom word is a fixed function of the address
`timescale 1ns/10ps
module pcs_mem_model #(
   parameter int PC_WIDTH = pcs_pkg::PCS_LARGE_WIDTH
) (
   input  wire logic                sys_clk,
   input  wire logic                rst_n,
   input  wire logic [PC_WIDTH-1:0] romAddr,
   input  wire logic                stackPush,
   input  wire logic [PC_WIDTH-1:0] stackPushData,
   input  wire logic                stackPop,
   output logic [15:0]              romData,
   output logic [PC_WIDTH-1:0]      stackTop
);
   logic [PC_WIDTH-1:0] stackMem [0:15];
   logic [3:0]          stackPtr;
   assign romData = 16'h5a3c ^ (16'(romAddr) * 16'h0007);
   // Pushed value shows at once, a pop in flight exposes the entry below
   // Empty stack shows a changing pattern
   always_comb begin
      if (stackPush) stackTop = stackPushData;
      else if (stackPop && stackPtr > 4'h1) stackTop = stackMem[stackPtr - 4'h2];
      else if (stackPop || stackPtr == 4'h0) stackTop = ~stackPushData;
      else stackTop = stackMem[stackPtr - 4'h1];
   end
   always_ff @(posedge sys_clk) begin
      if (!rst_n) stackPtr <= 4'h0;
      else if (stackPush) begin
         stackMem[stackPtr] <= stackPushData;
         stackPtr <= stackPtr + 4'h1;
      end else if (stackPop) stackPtr <= stackPtr - 4'h1;
   end
endmodule // pcs_mem_model

// ===== pcs_pkg.sv
// Purpose: Constants for the program counter sequencer
// Assumes: 16-bit program words, one system clock
// Notes:   Vector addresses are fixed by the memory map
package pcs_pkg;
   // ****************************************
   // Widths
   // ****************************************
   localparam int PCS_SMALL_WIDTH = 10;
   localparam int PCS_LARGE_WIDTH = 11;
   localparam int PCS_WORD_WIDTH  = 16;
   localparam int PCS_SRC_COUNT   = 5;
   // ****************************************
   // Addresses
   // ****************************************
   localparam logic [10:0] PCS_RESET_ADDR  = 11'h000;
   localparam logic [10:0] PCS_SMALL_TOP   = 11'h3ff;
   localparam logic [10:0] PCS_LARGE_TOP   = 11'h7ff;
   // Vector per source: serial, interval timer, timer 1, timer 0, external pin
   localparam logic [10:0] PCS_VEC_SERIAL  = 11'h001;
   localparam logic [10:0] PCS_VEC_BTIMER  = 11'h002;
   localparam logic [10:0] PCS_VEC_TIMER1  = 11'h003;
   localparam logic [10:0] PCS_VEC_TIMER0  = 11'h004;
   localparam logic [10:0] PCS_VEC_EXTPIN  = 11'h005;
   // ****************************************
   // Operations presented by the decoder
   // ****************************************
   typedef enum logic [3:0] {
      PCS_OP_NONE,
      PCS_OP_JUMP_DIRECT,
      PCS_OP_JUMP_INDIRECT,
      PCS_OP_CALL_DIRECT,
      PCS_OP_CALL_INDIRECT,
      PCS_OP_RETURN,
      PCS_OP_RETURN_SKIP,
      PCS_OP_RETURN_INT,
      PCS_OP_TABLE_READ,
      PCS_OP_SKIP
   } pcs_op_e;
endpackage : pcs_pkg

// ===== pcs_sequencer.sv
// Purpose: Next-address logic for the instruction pointer
// Assumes: Decoder presents one operation per instrStep pulse
// Notes:   Stack storage lives outside; push/pop are strobes to it
//
// What this block does
// - Pointer is 10 or 11 bit counter
// - Increment each instruction unless redirected
// - Reset low forces pointer to zero
// - Direct jump loads operand, no stack
// - Indirect jump loads branch address register
// - Direct call pushes pointer plus one, loads operand
// - Call operand range per ROM size
// - Indirect call pushes, loads branch register
// - Returns reload pointer from stack
// - Table read saves, fetches word, restores
// - Table read borrows one stack level
// - True skip turns next instruction into nop unless an interrupt takes that step
// - Skip keeps count and timing equal
// - Interrupt pushes pointer, loads vector
// - Pointer spans whole 16-bit word ROM
// - Lowest addresses hold reset and vectors
// - Vector table one to five
// - Return-and-skip nops first returned instruction unless an interrupt takes that step
// - Table read takes two instruction cycles
`timescale 1ns/10ps
module pcs_sequencer #(
   parameter int  PC_WIDTH  = pcs_pkg::PCS_LARGE_WIDTH,
   parameter int  SRC_COUNT = pcs_pkg::PCS_SRC_COUNT
) (
   input  wire logic                               sys_clk,
   input  wire logic                               rst_n,
   input  wire logic                               instrStep,
   input  wire pcs_pkg::pcs_op_e                   opCode,
   input  wire logic [PC_WIDTH-1:0]                operandAddr,
   input  wire logic                               skipTrue,
   input  wire logic [PC_WIDTH-1:0]                branchAddressRegister,
   input  wire logic [PC_WIDTH-1:0]                stackTop,
   input  wire logic [SRC_COUNT-1:0]               intReq,
   input  wire logic [pcs_pkg::PCS_WORD_WIDTH-1:0] romData,
   output logic [PC_WIDTH-1:0]                     instructionPointer,
   output logic [PC_WIDTH-1:0]                     romAddr,
   output logic                                    stackPush,
   output logic [PC_WIDTH-1:0]                     stackPushData,
   output logic                                    stackPop,
   output logic                                    intAck,
   output logic                                    nopNext,
   output logic                                    busy,
   output logic [pcs_pkg::PCS_WORD_WIDTH-1:0]      tableDataBuffer,
   output logic                                    tableDataValid
);
   // ****************************************
   // State
   // ****************************************
   typedef enum logic [1:0] {PCS_RUN, PCS_TABLE_FETCH} pcs_state_e;

   pcs_state_e                          state;
   pcs_state_e                          next_state;
   logic [PC_WIDTH-1:0]                 next_instructionPointer;
   logic [PC_WIDTH-1:0]                 next_romAddr;
   logic                                next_stackPush;
   logic [PC_WIDTH-1:0]                 next_stackPushData;
   logic                                next_stackPop;
   logic                                next_intAck;
   logic                                next_nopNext;
   logic                                next_busy;
   logic [pcs_pkg::PCS_WORD_WIDTH-1:0]  next_tableDataBuffer;
   logic                                next_tableDataValid;
   logic                                anyReq;
   logic [10:0]                         vector;
   logic [PC_WIDTH-1:0]                 incPointer;

   localparam logic [PC_WIDTH-1:0] ONE = PC_WIDTH'(1);

   pcs_vector_select #(
      .SRC_COUNT(SRC_COUNT)
   ) u_vec (
      .intReq (intReq),
      .anyReq (anyReq),
      .vector (vector)
   );

   // Natural wrap at implemented width
   assign incPointer = instructionPointer + ONE;

   function automatic logic [PC_WIDTH-1:0] clip(input logic [PC_WIDTH-1:0] a);
      // Mask is all ones at both widths; no bit is dropped
      clip = a;
      if (PC_WIDTH > pcs_pkg::PCS_SMALL_WIDTH) begin
         clip = a;
      end
      clip = a & pcs_pkg::PCS_LARGE_TOP[PC_WIDTH-1:0];
   endfunction

   // ****************************************
   // Next values
   // ****************************************
   always_comb begin
      next_state              = state;
      next_instructionPointer = instructionPointer;
      next_romAddr            = romAddr;
      next_stackPush          = 1'b0;
      next_stackPushData      = stackPushData;
      next_stackPop           = 1'b0;
      next_intAck             = 1'b0;
      next_nopNext            = nopNext;
      next_busy               = busy;
      next_tableDataBuffer    = tableDataBuffer;
      next_tableDataValid     = 1'b0;
      if (!rst_n) begin
         next_state              = PCS_RUN;
         next_instructionPointer = pcs_pkg::PCS_RESET_ADDR[PC_WIDTH-1:0];
         next_romAddr            = pcs_pkg::PCS_RESET_ADDR[PC_WIDTH-1:0];
         next_stackPushData      = '0;
         next_nopNext            = 1'b0;
         next_busy               = 1'b0;
         next_tableDataBuffer    = '0;
      end else begin
         case (state)
            PCS_RUN: begin
               if (instrStep) begin
                  next_nopNext = 1'b0;
                  if (anyReq) begin
                     // Interrupt beats the instruction transfer
                     next_stackPush          = 1'b1;
                     next_stackPushData      = instructionPointer;
                     next_instructionPointer = vector[PC_WIDTH-1:0];
                     next_intAck             = 1'b1;
                  end else if (nopNext) begin
                     // Squashed slot still costs one cycle
                     next_instructionPointer = incPointer;
                  end else begin
                     next_instructionPointer = incPointer;
                     case (opCode)
                        pcs_pkg::PCS_OP_JUMP_DIRECT: begin
                           next_instructionPointer = clip(operandAddr);
                        end
                        pcs_pkg::PCS_OP_JUMP_INDIRECT: begin
                           next_instructionPointer = branchAddressRegister;
                        end
                        pcs_pkg::PCS_OP_CALL_DIRECT: begin
                           next_stackPush          = 1'b1;
                           next_stackPushData      = incPointer;
                           next_instructionPointer = clip(operandAddr);
                        end
                        pcs_pkg::PCS_OP_CALL_INDIRECT: begin
                           next_stackPush          = 1'b1;
                           next_stackPushData      = incPointer;
                           next_instructionPointer = branchAddressRegister;
                        end
                        pcs_pkg::PCS_OP_RETURN,
                        pcs_pkg::PCS_OP_RETURN_INT: begin
                           next_stackPop           = 1'b1;
                           next_instructionPointer = stackTop;
                        end
                        pcs_pkg::PCS_OP_RETURN_SKIP: begin
                           next_stackPop           = 1'b1;
                           next_instructionPointer = stackTop;
                           next_nopNext            = 1'b1;
                        end
                        pcs_pkg::PCS_OP_TABLE_READ: begin
                           // Borrow one stack level for the return point
                           next_stackPush          = 1'b1;
                           next_stackPushData      = incPointer;
                           next_instructionPointer = branchAddressRegister;
                           next_busy               = 1'b1;
                           next_state              = PCS_TABLE_FETCH;
                        end
                        pcs_pkg::PCS_OP_SKIP: begin
                           next_nopNext = skipTrue;
                        end
                        default: begin
                           next_instructionPointer = incPointer;
                        end
                     endcase
                  end
                  next_romAddr = next_instructionPointer;
               end
            end
            PCS_TABLE_FETCH: begin
               // Second cycle: capture word, restore from stack
               next_tableDataBuffer    = romData;
               next_tableDataValid     = 1'b1;
               next_stackPop           = 1'b1;
               next_instructionPointer = stackTop;
               next_romAddr            = stackTop;
               next_busy               = 1'b0;
               next_state              = PCS_RUN;
            end
            default: begin
               next_state = PCS_RUN;
            end
         endcase
      end
   end

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge sys_clk) begin
      state              <= next_state;
      instructionPointer <= next_instructionPointer;
      romAddr            <= next_romAddr;
      stackPush          <= next_stackPush;
      stackPushData      <= next_stackPushData;
      stackPop           <= next_stackPop;
      intAck             <= next_intAck;
      nopNext            <= next_nopNext;
      busy               <= next_busy;
      tableDataBuffer    <= next_tableDataBuffer;
      tableDataValid     <= next_tableDataValid;
   end

   // ****************************************
   // Checks
   // ****************************************
   reset_zero_a: assert property (
      @(posedge sys_clk) !rst_n |=> instructionPointer == '0)
      else $error("Pointer not zero after reset");
   reset_quiet_a: assert property (
      @(posedge sys_clk) !rst_n
      |=> !stackPush && !stackPop && !intAck && !busy && !tableDataValid && !nopNext)
      else $error("Strobes not quiet after reset");
   increment_a: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (state == PCS_RUN && instrStep && !anyReq && opCode == pcs_pkg::PCS_OP_NONE)
      |=> instructionPointer == $past(instructionPointer) + ONE)
      else $error("Pointer did not increment");
   nop_slot_a: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (state == PCS_RUN && instrStep && !anyReq && nopNext)
      |=> instructionPointer == $past(instructionPointer) + ONE && !stackPush && !stackPop)
      else $error("Squashed slot did not advance plainly");
   jump_direct_a: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (state == PCS_RUN && instrStep && !anyReq && !nopNext
       && opCode == pcs_pkg::PCS_OP_JUMP_DIRECT)
      |=> instructionPointer == $past(operandAddr) && !stackPush)
      else $error("Direct jump wrong");
   jump_indirect_a: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (state == PCS_RUN && instrStep && !anyReq && !nopNext
       && opCode == pcs_pkg::PCS_OP_JUMP_INDIRECT)
      |=> instructionPointer == $past(branchAddressRegister))
      else $error("Indirect jump wrong");
   call_direct_a: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (state == PCS_RUN && instrStep && !anyReq && !nopNext
       && opCode == pcs_pkg::PCS_OP_CALL_DIRECT)
      |=> stackPush && stackPushData == $past(instructionPointer) + ONE
          && instructionPointer == $past(operandAddr))
      else $error("Direct call wrong");
   call_push_a: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (state == PCS_RUN && instrStep && !anyReq && !nopNext
       && opCode == pcs_pkg::PCS_OP_CALL_INDIRECT)
      |=> stackPush && stackPushData == $past(instructionPointer) + ONE
          && instructionPointer == $past(branchAddressRegister))
      else $error("Call did not push return");
   return_pop_a: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (state == PCS_RUN && instrStep && !anyReq && !nopNext
       && opCode == pcs_pkg::PCS_OP_RETURN)
      |=> stackPop && instructionPointer == $past(stackTop))
      else $error("Return did not reload");
   return_skip_a: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (state == PCS_RUN && instrStep && !anyReq && !nopNext
       && opCode == pcs_pkg::PCS_OP_RETURN_SKIP)
      |=> stackPop && nopNext && instructionPointer == $past(stackTop))
      else $error("Return and skip wrong");
   int_vector_a: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (state == PCS_RUN && instrStep && intReq[0])
      |=> intAck && stackPush && stackPushData == $past(instructionPointer)
          && instructionPointer == pcs_pkg::PCS_VEC_SERIAL[PC_WIDTH-1:0])
      else $error("Interrupt vector wrong");
   int_priority_a: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (state == PCS_RUN && instrStep && anyReq)
      |=> intAck && !stackPop && instructionPointer == $past(vector[PC_WIDTH-1:0]))
      else $error("Interrupt did not win");
   table_two_a: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (state == PCS_RUN && instrStep && !anyReq && !nopNext
       && opCode == pcs_pkg::PCS_OP_TABLE_READ)
      |=> busy ##1 (!busy && tableDataValid && stackPop))
      else $error("Table read not two cycles");
   table_fetch_a: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (state == PCS_TABLE_FETCH)
      |=> tableDataBuffer == $past(romData) && instructionPointer == $past(stackTop)
          && romAddr == $past(stackTop))
      else $error("Table fetch did not restore");
   busy_hold_a: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (state == PCS_TABLE_FETCH)
      |=> !stackPush && !intAck)
      else $error("Step taken while busy");
   skip_nop_a: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (state == PCS_RUN && instrStep && !anyReq && !nopNext
       && opCode == pcs_pkg::PCS_OP_SKIP && skipTrue) |=> nopNext)
      else $error("Skip not squashing");
   cov_call_c: cover property (@(posedge sys_clk) stackPush && !intAck);
   cov_retskip_c: cover property (@(posedge sys_clk) stackPop && nopNext);
   cov_int_c: cover property (@(posedge sys_clk) intAck);
   cov_table_c: cover property (@(posedge sys_clk) tableDataValid);
   cov_skip_c: cover property (@(posedge sys_clk) nopNext && instrStep);
endmodule // pcs_sequencer

// ===== pcs_vector_select.sv
// Purpose: Pick vector address of highest-priority pending interrupt
// Assumes: Request vector bit 0 is serial, bit 4 the external pin
// Notes:   Combinational; lowest vector wins
`timescale 1ns/10ps
module pcs_vector_select #(
   parameter int SRC_COUNT = pcs_pkg::PCS_SRC_COUNT
) (
   input  wire logic [SRC_COUNT-1:0] intReq,
   output logic                      anyReq,
   output logic [10:0]               vector
);
   // ****************************************
   // Priority pick
   // ****************************************
   always_comb begin
      anyReq = 1'b0;
      vector = pcs_pkg::PCS_VEC_SERIAL;
      for (int i = SRC_COUNT - 1; i >= 0; i--) begin
         if (intReq[i]) begin
            anyReq = 1'b1;
            vector = pcs_pkg::PCS_VEC_SERIAL + 11'(i);
         end
      end
   end
endmodule // pcs_vector_select

// ===== testbench.sv
// Purpose: Self-checking bench for the program counter sequencer
// Assumes: Large variant, 11-bit pointer
// Notes:   Driver queues notes, monitor compares them
`timescale 1ns/10ps
module testbench;
   typedef struct packed {
      logic [10:0] ptr; logic push; logic [10:0] data; logic pop;
      logic ack; logic nop; logic bsy; logic valid; logic [15:0] tbuf;
   } pcs_note_s;
   logic sys_clk, rst_n, instrStep, skipTrue, stackPush, stackPop;
   logic intAck, nopNext, busy, tableDataValid, due;
   logic [10:0] operandAddr, branchAddressRegister, stackTop, instructionPointer;
   logic [10:0] romAddr, stackPushData, ptrM, a;
   logic [4:0]  intReq;
   logic [15:0] romData, tableDataBuffer;
   logic        nopM;
   pcs_pkg::pcs_op_e opCode;
   pcs_note_s   notes[$];
   pcs_note_s   mn;
   logic [10:0] stk[$];
   int          error_cnt, comparisons, seed;
   pcs_sequencer #(.PC_WIDTH(11), .SRC_COUNT(5)) u_dut (.sys_clk(sys_clk), .rst_n(rst_n),
      .instrStep(instrStep), .opCode(opCode), .operandAddr(operandAddr),
      .skipTrue(skipTrue), .branchAddressRegister(branchAddressRegister),
      .stackTop(stackTop), .intReq(intReq), .romData(romData),
      .instructionPointer(instructionPointer), .romAddr(romAddr), .stackPush(stackPush),
      .stackPushData(stackPushData), .stackPop(stackPop), .intAck(intAck),
      .nopNext(nopNext), .busy(busy), .tableDataBuffer(tableDataBuffer),
      .tableDataValid(tableDataValid));
   pcs_mem_model #(.PC_WIDTH(11)) u_mem (.sys_clk(sys_clk), .rst_n(rst_n), .romAddr(romAddr),
      .stackPush(stackPush), .stackPushData(stackPushData), .stackPop(stackPop),
      .romData(romData), .stackTop(stackTop));
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic final_report();
      $display("Checks %0d, mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // ****************************************
   // One instruction with its expected outcome
   // ****************************************
   task automatic step(input pcs_pkg::pcs_op_e op, input logic [10:0] opnd,
                       input logic [10:0] ar, input logic sk, input logic [4:0] irq);
      pcs_note_s n;
      pcs_note_s f;
      logic [10:0] nx;
      logic        nopOld;
      @(negedge sys_clk);
      instrStep = 1'b1;
      opCode = op;
      operandAddr = opnd;
      branchAddressRegister = ar;
      skipTrue = sk;
      intReq = irq;
      n = '0;
      f = '0;
      nx = ptrM + 11'h1;
      nopOld = nopM;
      nopM = 1'b0;
      if (irq != 5'h0) begin
         n.push = 1'b1;
         n.ack = 1'b1;
         n.data = ptrM;
         stk.push_back(ptrM);
         for (int i = 4; i >= 0; i--) if (irq[i]) nx = 11'(i + 1);
      end else if (!nopOld) begin
         case (op)
            pcs_pkg::PCS_OP_JUMP_DIRECT: nx = opnd;
            pcs_pkg::PCS_OP_JUMP_INDIRECT: nx = ar;
            pcs_pkg::PCS_OP_CALL_DIRECT, pcs_pkg::PCS_OP_CALL_INDIRECT,
            pcs_pkg::PCS_OP_TABLE_READ: begin
               n.push = 1'b1;
               n.data = nx;
               stk.push_back(nx);
               nx = (op == pcs_pkg::PCS_OP_CALL_DIRECT) ? opnd : ar;
            end
            pcs_pkg::PCS_OP_RETURN, pcs_pkg::PCS_OP_RETURN_SKIP,
            pcs_pkg::PCS_OP_RETURN_INT: begin
               n.pop = 1'b1;
               nx = stk.pop_back();
               nopM = (op == pcs_pkg::PCS_OP_RETURN_SKIP);
            end
            pcs_pkg::PCS_OP_SKIP: nopM = sk;
            default: ;
         endcase
         if (op == pcs_pkg::PCS_OP_TABLE_READ) begin
            n.bsy = 1'b1;
            f.pop = 1'b1;
            f.valid = 1'b1;
            f.ptr = stk.pop_back();
            f.tbuf = 16'h5a3c ^ (16'(ar) * 16'h0007);
         end
      end
      n.ptr = nx;
      n.nop = nopM;
      ptrM = nx;
      notes.push_back(n);
      if (f.valid) begin
         notes.push_back(f);
         ptrM = f.ptr;
         @(negedge sys_clk);
         opCode = pcs_pkg::PCS_OP_JUMP_DIRECT;
         operandAddr = 11'($urandom);
      end
   endtask
   task automatic drain();
      @(negedge sys_clk);
      instrStep = 1'b0;
      intReq = 5'h00;
      for (int i = 0; i < 20 && notes.size() > 0; i++) @(negedge sys_clk);
      if (notes.size() > 0) begin
         error_cnt++;
         final_report();
      end
   endtask
   initial begin
      forever begin
         @(posedge sys_clk);
         due = (rst_n === 1'b1) && ((instrStep === 1'b1) || (busy === 1'b1));
         @(negedge sys_clk);
         if (due && notes.size() == 0) chk("noteQueue", 16'h1, 16'h0);
         else if (due) begin
            mn = notes.pop_front();
            chk("pointer", 16'(instructionPointer), 16'(mn.ptr));
            chk("romAddr", 16'(romAddr), 16'(mn.ptr));
            chk("push", 16'(stackPush), 16'(mn.push));
            if (mn.push) chk("pushData", 16'(stackPushData), 16'(mn.data));
            chk("pop", 16'(stackPop), 16'(mn.pop));
            chk("intAck", 16'(intAck), 16'(mn.ack));
            chk("nopNext", 16'(nopNext), 16'(mn.nop));
            chk("busy", 16'(busy), 16'(mn.bsy));
            chk("valid", 16'(tableDataValid), 16'(mn.valid));
            if (mn.valid) chk("buffer", tableDataBuffer, mn.tbuf);
         end
      end
   end
   initial begin
      rst_n = 1'b0;
      {instrStep, skipTrue, intReq, operandAddr, branchAddressRegister} = '0;
      opCode = pcs_pkg::PCS_OP_NONE;
      {error_cnt, comparisons, ptrM, nopM} = '0;
      seed = $urandom(88);
      repeat (16) @(negedge sys_clk);
      rst_n = 1'b1;
      chk("resetPointer", 16'(instructionPointer), 16'h0);
      a = 11'($urandom);
      for (int i = 0; i < 10; i++) step(pcs_pkg::pcs_op_e'(i), 11'($urandom), a, 1'b0, 5'h0);
      step(pcs_pkg::PCS_OP_CALL_DIRECT, 11'h7ff, a, 1'b0, 5'h0);
      step(pcs_pkg::PCS_OP_RETURN_SKIP, 11'h0, a, 1'b0, 5'h0);
      step(pcs_pkg::PCS_OP_JUMP_DIRECT, 11'($urandom), a, 1'b0, 5'h0);
      step(pcs_pkg::PCS_OP_SKIP, 11'h0, a, 1'b1, 5'h0);
      step(pcs_pkg::PCS_OP_JUMP_INDIRECT, 11'h0, 11'($urandom), 1'b0, 5'h0);
      step(pcs_pkg::PCS_OP_SKIP, 11'h0, a, 1'b0, 5'h0);
      step(pcs_pkg::PCS_OP_JUMP_DIRECT, 11'h7ff, a, 1'b0, 5'h0);
      step(pcs_pkg::PCS_OP_NONE, 11'h0, a, 1'b0, 5'h0);
      drain();
      $display("Test operations done");
      for (int i = 0; i < 3; i++)
         step(pcs_pkg::PCS_OP_TABLE_READ, 11'h0, 11'($urandom), 1'b0, 5'h0);
      drain();
      $display("Test table read done");
      for (int i = 0; i < 5; i++) begin
         step(pcs_pkg::PCS_OP_JUMP_DIRECT, 11'($urandom), a, 1'b0,
              5'((5'h1 << i) | (5'h1f << i & 5'($urandom))));
         step(pcs_pkg::PCS_OP_RETURN_INT, 11'h0, a, 1'b0, 5'h0);
      end
      drain();
      $display("Test interrupts done");
      step(pcs_pkg::PCS_OP_CALL_DIRECT, 11'($urandom), a, 1'b0, 5'h0);
      rst_n = 1'b0;
      notes.delete();
      stk.delete();
      {ptrM, nopM} = '0;
      @(negedge sys_clk);
      rst_n = 1'b1;
      instrStep = 1'b0;
      chk("midResetPointer", 16'(instructionPointer), 16'h0);
      chk("midResetPush", 16'(stackPush), 16'h0);
      $display("Test reset done");
      drain();
      final_report();
   end
endmodule // testbench
